/* flash_sector_protection_pkg.sv */
/*
 Constants for the sector guard block: register map, field positions,
 command codes and timing. Assumes a 100 MHz clock and a 32-bit AXI4-Lite bus.
*/
`default_nettype none
package flash_sector_protection_pkg;
   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int SECTOR_COUNT = 256;
   localparam int SECTOR_W = 8;
   localparam int ADDR_W = 8;
   localparam int CNT_W = 24;
   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFS_COMMAND = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_TARGET = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_DATA_LO = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_DATA_HI = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_LOCK = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_MODE = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_GUARDS = 8'h1c;
   localparam logic [ADDR_W-1:0] OFS_PASS_LO = 8'h20;
   localparam logic [ADDR_W-1:0] OFS_PASS_HI = 8'h24;
   localparam logic [ADDR_W-1:0] OFS_CONFIG = 8'h28;
   localparam logic [ADDR_W-1:0] OFS_LEARN = 8'h2c;
   localparam logic [ADDR_W-1:0] OFS_RANGE = 8'h30;
   // ----------------------------------------------------------------
   // Fields
   // ----------------------------------------------------------------
   localparam int STAT_WIP = 0;
   localparam int STAT_EERR = 5;
   localparam int STAT_PERR = 6;
   localparam int MODE_LO = 1;
   localparam int MODE_HI = 2;
   localparam int CFG1_LO = 2;
   localparam int CFG1_HI = 5;
   localparam int RANGE_EN = 16;
   localparam logic [1:0] MODE_NONE = 2'h3;
   localparam logic [1:0] MODE_PERSIST = 2'h2;
   localparam logic [1:0] MODE_PASSWORD = 2'h1;
   localparam logic [1:0] MODE_ILLEGAL = 2'h0;
   localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
   localparam logic [31:0] LEARN_RESET = 32'h0000_0000;
   localparam logic [63:0] PASS_RESET = 64'hffff_ffff_ffff_ffff;
   localparam logic [31:0] PASS_HIDDEN = 32'hffff_ffff;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ----------------------------------------------------------------
   // Command codes
   // ----------------------------------------------------------------
   localparam logic [3:0] CMD_MODE_PROG = 4'h1;
   localparam logic [3:0] CMD_GUARD_PROG = 4'h2;
   localparam logic [3:0] CMD_GUARD_ERASE = 4'h3;
   localparam logic [3:0] CMD_VGUARD_WRITE = 4'h4;
   localparam logic [3:0] CMD_LOCK_CLEAR = 4'h5;
   localparam logic [3:0] CMD_PASS_PROG = 4'h6;
   localparam logic [3:0] CMD_PASS_UNLOCK = 4'h7;
   localparam logic [3:0] CMD_CONFIG_PROG = 4'h8;
   localparam logic [3:0] CMD_LEARN_PROG = 4'h9;
   localparam logic [3:0] CMD_ARRAY_PROG = 4'ha;
   localparam logic [3:0] CMD_ARRAY_ERASE = 4'hb;
   localparam logic [3:0] CMD_SOFT_RESET = 4'hc;
   localparam logic [3:0] CMD_CLEAR_STATUS = 4'hd;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ = 100;
   localparam int PROG_TIME_US = 250;
   localparam int ERASE_TIME_US = 1000;
   localparam int UNLOCK_TIME_US = 100;
   localparam int QUICK_CYC = 1;
   typedef enum logic [0:0] {ST_IDLE, ST_BUSY} op_state_t;
endpackage
`default_nettype wire

/* flash_sector_protection.sv */
/*
 Sector guard logic of a serial NOR flash, reached over AXI4-Lite.
 Assumes the host issues one command at a time through the command register
 and that aresetn is power-on reset; hw_reset_n is the asynchronous reset pin.
*/
`default_nettype none
module flash_sector_protection #(
   parameter int PROG_CYC = flash_sector_protection_pkg::PROG_TIME_US *
      flash_sector_protection_pkg::CLK_MHZ,
   parameter int ERASE_CYC = flash_sector_protection_pkg::ERASE_TIME_US *
      flash_sector_protection_pkg::CLK_MHZ,
   parameter int UNLOCK_CYC = flash_sector_protection_pkg::UNLOCK_TIME_US *
      flash_sector_protection_pkg::CLK_MHZ
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic hw_reset_n,
   input wire logic [flash_sector_protection_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [flash_sector_protection_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic array_prog_go,
   output logic array_erase_go,
   output logic [flash_sector_protection_pkg::SECTOR_W-1:0] array_sector
);
   import flash_sector_protection_pkg::*;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return res;
   endfunction

   // ----------------------------------------------------------------
   // Reset pin filter
   // ----------------------------------------------------------------
   logic hw_q1_r, hw_q2_r, hw_q3_r, hw_ok_r;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hw_q1_r <= 1'b1;
         hw_q2_r <= 1'b1;
         hw_q3_r <= 1'b1;
         hw_ok_r <= 1'b1;
      end else begin
         hw_q1_r <= hw_reset_n;
         hw_q2_r <= hw_q1_r;
         hw_q3_r <= hw_q2_r;
         if (hw_q2_r == hw_q3_r) begin
            hw_ok_r <= hw_q3_r;
         end
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------------------------------
   logic aw_have_r, w_have_r;
   logic [ADDR_W-1:0] aw_addr_r, ar_addr;
   logic [31:0] w_data_r, rdata_nxt;
   logic [3:0] w_strb_r;
   logic wr_fire, rd_mapped;
   assign wr_fire = aw_have_r && w_have_r && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         aw_addr_r <= '0;
         w_data_r <= '0;
         w_strb_r <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_mapped(aw_addr_r) ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end
   assign s_axi_awready = !aw_have_r;
   assign s_axi_wready = !w_have_r;

   function automatic logic wr_mapped(input logic [ADDR_W-1:0] a);
      return a == OFS_COMMAND || a == OFS_TARGET || a == OFS_DATA_LO ||
             a == OFS_DATA_HI || a == OFS_RANGE;
   endfunction

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rdata_nxt;
         s_axi_rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
   assign s_axi_arready = !s_axi_rvalid;
   assign ar_addr = s_axi_araddr;

   // ----------------------------------------------------------------
   // Protection state
   // ----------------------------------------------------------------
   op_state_t state_r;
   logic [CNT_W-1:0] cnt_r;
   logic [1:0] mode_r;
   logic lock_r, perr_r, eerr_r, wip_r;
   logic [SECTOR_COUNT-1:0] pguard_r, vguard_r;
   logic [63:0] pass_r, data_r;
   logic [31:0] config_r, learn_r, range_r;
   logic [SECTOR_W-1:0] target_r;
   logic [3:0] cmd;
   logic cmd_go, idle, mode_chosen, pass_mode, range_hit, sec_guarded;
   logic protected_hit, unlock_ok, cfg_frozen_change, cfg_write, mode_write;
   logic [1:0] mode_new;
   logic [31:0] cfg_new, target_word;

   assign idle = state_r == ST_IDLE;
   assign cmd = w_data_r[3:0];
   assign cmd_go = wr_fire && aw_addr_r == OFS_COMMAND && w_strb_r[0] && idle && hw_ok_r;
   assign mode_chosen = mode_r != MODE_NONE;
   assign pass_mode = mode_r == MODE_PASSWORD;
   assign range_hit = range_r[RANGE_EN] && target_r >= range_r[7:0] &&
                      target_r <= range_r[15:8];
   // A sector is free only when both of its guard bits are one.
   assign sec_guarded = !(pguard_r[target_r] && vguard_r[target_r]);
   assign protected_hit = range_hit || sec_guarded;
   assign unlock_ok = pass_mode && data_r == pass_r;
   assign mode_new = mode_r & data_r[MODE_HI:MODE_LO];
   assign mode_write = cmd_go && cmd == CMD_MODE_PROG;
   assign cfg_write = cmd_go && cmd == CMD_CONFIG_PROG;
   assign cfg_new = data_r[31:0];
   assign target_word = merge({24'h0, target_r}, w_data_r, w_strb_r);
   assign cfg_frozen_change = cfg_new[31:8] != config_r[31:8] ||
                              cfg_new[CFG1_HI:CFG1_LO] != config_r[CFG1_HI:CFG1_LO];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         target_r <= '0;
         data_r <= '0;
         range_r <= '0;
      end else if (wr_fire) begin
         if (aw_addr_r == OFS_TARGET) begin
            target_r <= target_word[SECTOR_W-1:0];
         end else if (aw_addr_r == OFS_DATA_LO) begin
            data_r[31:0] <= merge(data_r[31:0], w_data_r, w_strb_r);
         end else if (aw_addr_r == OFS_DATA_HI) begin
            data_r[63:32] <= merge(data_r[63:32], w_data_r, w_strb_r);
         end else if (aw_addr_r == OFS_RANGE) begin
            range_r <= merge(range_r, w_data_r, w_strb_r);
         end
      end
   end

   // Command engine. Effects apply when the command is taken; the busy
   // count then only models the embedded operation time.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_r <= ST_IDLE;
         cnt_r <= '0;
         mode_r <= MODE_NONE;
         lock_r <= 1'b1;
         perr_r <= 1'b0;
         eerr_r <= 1'b0;
         wip_r <= 1'b0;
         pguard_r <= '1;
         vguard_r <= '1;
         pass_r <= PASS_RESET;
         config_r <= CONFIG_RESET;
         learn_r <= LEARN_RESET;
         array_prog_go <= 1'b0;
         array_erase_go <= 1'b0;
         array_sector <= '0;
      end else if (!hw_ok_r) begin
         state_r <= ST_IDLE;
         cnt_r <= '0;
         wip_r <= 1'b0;
         perr_r <= 1'b0;
         eerr_r <= 1'b0;
         vguard_r <= '1;
         lock_r <= !pass_mode;
         array_prog_go <= 1'b0;
         array_erase_go <= 1'b0;
      end else begin
         array_prog_go <= 1'b0;
         array_erase_go <= 1'b0;
         if (state_r == ST_BUSY) begin
            cnt_r <= cnt_r - 1'b1;
            if (cnt_r == CNT_W'(1)) begin
               state_r <= ST_IDLE;
               wip_r <= 1'b0;
            end
         end
         if (cmd_go && cmd != CMD_CLEAR_STATUS && cmd != CMD_SOFT_RESET) begin
            state_r <= ST_BUSY;
            wip_r <= 1'b1;
            cnt_r <= CNT_W'(QUICK_CYC);
         end
         if (cmd_go) begin
            case (cmd)
               CMD_MODE_PROG: begin
                  // Mode bits have no erase path; only ones may become zeros.
                  if (mode_chosen || mode_new == MODE_ILLEGAL) begin
                     perr_r <= 1'b1;
                  end else begin
                     mode_r <= mode_new;
                     cnt_r <= CNT_W'(PROG_CYC);
                  end
               end
               CMD_GUARD_PROG: begin
                  if (!lock_r) begin
                     perr_r <= 1'b1;
                  end else begin
                     pguard_r[target_r] <= 1'b0;
                     cnt_r <= CNT_W'(PROG_CYC);
                  end
               end
               CMD_GUARD_ERASE: begin
                  if (!lock_r) begin
                     eerr_r <= 1'b1;
                  end else begin
                     pguard_r <= '1;
                     cnt_r <= CNT_W'(ERASE_CYC);
                  end
               end
               CMD_VGUARD_WRITE: begin
                  vguard_r[target_r] <= data_r[0];
               end
               CMD_LOCK_CLEAR: begin
                  lock_r <= 1'b0;
               end
               CMD_PASS_PROG: begin
                  if (pass_mode) begin
                     perr_r <= perr_r;
                  end else if (mode_chosen) begin
                     perr_r <= 1'b1;
                  end else begin
                     pass_r <= pass_r & data_r;
                     cnt_r <= CNT_W'(PROG_CYC);
                  end
               end
               CMD_PASS_UNLOCK: begin
                  if (unlock_ok) begin
                     lock_r <= 1'b1;
                  end else begin
                     perr_r <= 1'b1;
                     cnt_r <= CNT_W'(UNLOCK_CYC);
                  end
               end
               CMD_CONFIG_PROG: begin
                  if (mode_chosen && cfg_frozen_change) begin
                     perr_r <= 1'b1;
                  end else begin
                     config_r <= cfg_new;
                     cnt_r <= CNT_W'(PROG_CYC);
                  end
               end
               CMD_LEARN_PROG: begin
                  if (mode_chosen) begin
                     perr_r <= 1'b1;
                  end else begin
                     learn_r <= data_r[31:0];
                     cnt_r <= CNT_W'(PROG_CYC);
                  end
               end
               CMD_ARRAY_PROG: begin
                  if (protected_hit) begin
                     perr_r <= 1'b1;
                  end else begin
                     array_prog_go <= 1'b1;
                     array_sector <= target_r;
                     cnt_r <= CNT_W'(PROG_CYC);
                  end
               end
               CMD_ARRAY_ERASE: begin
                  if (protected_hit) begin
                     eerr_r <= 1'b1;
                  end else begin
                     array_erase_go <= 1'b1;
                     array_sector <= target_r;
                     cnt_r <= CNT_W'(ERASE_CYC);
                  end
               end
               CMD_CLEAR_STATUS: begin
                  perr_r <= 1'b0;
                  eerr_r <= 1'b0;
               end
               default: begin
                  // Software reset leaves the lock bit as it is.
                  perr_r <= perr_r;
               end
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // Read decode
   // ----------------------------------------------------------------
   always_comb begin
      rd_mapped = 1'b1;
      rdata_nxt = '0;
      if (ar_addr == OFS_STATUS) begin
         rdata_nxt[STAT_WIP] = wip_r;
         rdata_nxt[STAT_EERR] = eerr_r;
         rdata_nxt[STAT_PERR] = perr_r;
      end else if (ar_addr == OFS_LOCK) begin
         rdata_nxt[0] = lock_r;
      end else if (ar_addr == OFS_MODE) begin
         rdata_nxt = {29'h1fff_ffff, mode_r, 1'b1};
      end else if (ar_addr == OFS_GUARDS) begin
         rdata_nxt[2:0] = {protected_hit, vguard_r[target_r], pguard_r[target_r]};
      end else if (ar_addr == OFS_PASS_LO) begin
         // The hidden password never leaves once password mode is chosen.
         rdata_nxt = pass_mode ? PASS_HIDDEN : pass_r[31:0];
      end else if (ar_addr == OFS_PASS_HI) begin
         rdata_nxt = pass_mode ? PASS_HIDDEN : pass_r[63:32];
      end else if (ar_addr == OFS_CONFIG) begin
         rdata_nxt = config_r;
      end else if (ar_addr == OFS_LEARN) begin
         rdata_nxt = learn_r;
      end else if (ar_addr == OFS_RANGE) begin
         rdata_nxt = range_r;
      end else if (ar_addr == OFS_TARGET) begin
         rdata_nxt[SECTOR_W-1:0] = target_r;
      end else if (ar_addr == OFS_DATA_LO) begin
         rdata_nxt = data_r[31:0];
      end else if (ar_addr == OFS_DATA_HI) begin
         rdata_nxt = data_r[63:32];
      end else if (ar_addr != OFS_COMMAND) begin
         rd_mapped = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   sequence unlock_fail_s;
      cmd_go && cmd == CMD_PASS_UNLOCK && !unlock_ok;
   endsequence
   sequence held_busy_s;
      wip_r && perr_r && !lock_r;
   endsequence

   mode_legal_a: assert property (@(posedge aclk) disable iff (!aresetn)
      mode_r != MODE_ILLEGAL) else $error("mode bits reached 00");
   mode_permanent_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(mode_r) != MODE_NONE |-> mode_r == $past(mode_r))
      else $error("chosen mode changed");
   lock_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
      cmd_go && cmd == CMD_LOCK_CLEAR && hw_ok_r |=> !lock_r)
      else $error("lock clear did not clear lock");
   guard_frozen_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !lock_r |=> pguard_r == $past(pguard_r))
      else $error("persistent guards changed while locked");
   pass_clear_only_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (pass_r & ~$past(pass_r)) == 64'h0) else $error("password bit rose");
   unlock_delay_a: assert property (@(posedge aclk) disable iff (!aresetn || !hw_ok_r)
      (unlock_fail_s and !lock_r) |=> held_busy_s[*2])
      else $error("failed unlock not held busy");
   lock_cause_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(lock_r) && hw_ok_r && $past(hw_ok_r) |->
      $past(cmd_go && cmd == CMD_PASS_UNLOCK && unlock_ok))
      else $error("lock set without password match");
   protect_reject_a: assert property (@(posedge aclk) disable iff (!aresetn)
      cmd_go && cmd == CMD_ARRAY_PROG && protected_hit |=> perr_r && !array_prog_go)
      else $error("protected sector programmed");
   config_frozen_a: assert property (@(posedge aclk) disable iff (!aresetn)
      cfg_write && mode_chosen && cfg_frozen_change |=> perr_r && $stable(config_r))
      else $error("frozen configuration changed");
endmodule
`default_nettype wire

/* array_model.sv */
/*
 Stand-in for the flash array behind the guard block.
 Assumes go pulses last one clock and the sector is valid with them.
*/
`default_nettype none
module array_model (
   input wire logic aclk,
   input wire logic prog_go,
   input wire logic erase_go,
   input wire logic [7:0] sector,
   output logic [7:0] n_ops,
   output logic [7:0] last_sector
);
   timeunit 1ns;
   timeprecision 1ns;
   initial n_ops = 8'h00;
   // Counting pulses shows a refused command, which leaves no trace here.
   always @(posedge aclk) begin
      if (prog_go || erase_go) begin
         n_ops <= n_ops + 8'h01;
         last_sector <= sector;
      end
   end
endmodule
`default_nettype wire

/* tb_flash_sector_protection.sv */
/*
 Self-checking bench for the sector guard block.
 Assumes the register map and command codes of the block's package.
*/
`default_nettype none
module tb_flash_sector_protection;
   import flash_sector_protection_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic aclk = 0, aresetn = 0, hw_reset_n = 1, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid, pgo, ego;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, sec, n_ops, last_sec;
   logic [31:0] wdata = 32'h0, rdata, v;
   logic [1:0] bresp, rresp;
   int fail_count = 0, n_tests = 0;
   flash_sector_protection #(.PROG_CYC(20), .ERASE_CYC(40), .UNLOCK_CYC(10)) i_flash_sector_protection (
      .aclk(aclk), .aresetn(aresetn), .hw_reset_n(hw_reset_n), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awv), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wv), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .array_prog_go(pgo),
      .array_erase_go(ego), .array_sector(sec));
   array_model i_array_model (.aclk(aclk), .prog_go(pgo), .erase_go(ego), .sector(sec),
      .n_ops(n_ops), .last_sector(last_sec));
   initial forever #5 aclk = ~aclk;
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
         fail_count++;
      end
   endtask
   task automatic tmo(input int i);
      if (i >= 400) begin
         fail_count++;
         stop_test();
      end
   endtask
   // ----------------------------------------------------------------
   // Bus cycles: each channel is released only at the edge that takes it.
   // ----------------------------------------------------------------
   // Handshakes are judged on values settled before the edge that takes them.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int i;
      logic aw_ok, w_ok, b_ok;
      b_ok = 0;
      @(posedge aclk);
      awaddr <= a; wdata <= d; awv <= 1; wv <= 1; bready <= 1;
      for (i = 0; i < 400 && !b_ok; i++) begin
         @(negedge aclk);
         aw_ok = awv && awready;
         w_ok = wv && wready;
         b_ok = bvalid;
         @(posedge aclk);
         if (aw_ok) awv <= 0;
         if (w_ok) wv <= 0;
      end
      tmo(i);
      bready <= 0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      int i;
      logic ar_ok, r_ok;
      r_ok = 0;
      d = 32'h0;
      @(posedge aclk);
      araddr <= a; arv <= 1; rready <= 1;
      for (i = 0; i < 400 && !r_ok; i++) begin
         @(negedge aclk);
         ar_ok = arv && arready;
         r_ok = rvalid;
         if (r_ok) d = (rresp == RESP_OKAY) ? rdata : 32'hdead_0000;
         @(posedge aclk);
         if (ar_ok) arv <= 0;
      end
      tmo(i);
      rready <= 0;
   endtask
   // Issues one command, then polls until it has finished.
   task automatic cmd(input logic [3:0] c, input logic [7:0] t, input logic [31:0] lo,
      input logic [31:0] hi);
      int i;
      wr(OFS_TARGET, {24'h0, t}); wr(OFS_DATA_LO, lo); wr(OFS_DATA_HI, hi);
      wr(OFS_COMMAND, {28'h0, c});
      v = 32'h1;
      for (i = 0; i < 400 && v[STAT_WIP] !== 1'b0; i++) rd(OFS_STATUS, v);
      tmo(i);
   endtask
   task automatic t_reset();
      rd(OFS_STATUS, v); chk(v, 32'h0);
      rd(OFS_LOCK, v); chk(v[0], 1'b1);
      rd(OFS_PASS_HI, v); chk(v, 32'hffff_ffff);
      rd(8'h3c, v); chk(v, 32'hdead_0000);
      cmd(CMD_MODE_PROG, 8'h0, 32'h0, 32'h0); chk(v[STAT_PERR], 1'b1);
      rd(OFS_MODE, v); chk(v, 32'hffff_ffff);
      cmd(CMD_CLEAR_STATUS, 8'h0, 32'h0, 32'h0);
      $display("reset and mode test done");
   endtask
   task automatic t_guard();
      cmd(CMD_GUARD_PROG, 8'h05, 32'h0, 32'h0); chk(v, 32'h0);
      rd(OFS_GUARDS, v); chk(v[2:0], 3'b110);
      cmd(CMD_ARRAY_PROG, 8'h05, 32'h0, 32'h0); chk(v[STAT_PERR], 1'b1);
      cmd(CMD_CLEAR_STATUS, 8'h0, 32'h0, 32'h0);
      cmd(CMD_VGUARD_WRITE, 8'h06, 32'h0, 32'h0);
      cmd(CMD_ARRAY_ERASE, 8'h06, 32'h0, 32'h0); chk(v[STAT_EERR], 1'b1);
      cmd(CMD_CLEAR_STATUS, 8'h0, 32'h0, 32'h0);
      cmd(CMD_ARRAY_PROG, 8'h07, 32'h0, 32'h0); chk(v, 32'h0);
      chk({n_ops, last_sec}, 16'h0107);
      wr(OFS_RANGE, 32'h0001_0808);
      cmd(CMD_ARRAY_PROG, 8'h08, 32'h0, 32'h0); chk(v[STAT_PERR], 1'b1);
      wr(OFS_RANGE, 32'h0);
      cmd(CMD_CLEAR_STATUS, 8'h0, 32'h0, 32'h0);
      cmd(CMD_LOCK_CLEAR, 8'h0, 32'h0, 32'h0);
      rd(OFS_LOCK, v); chk(v[0], 1'b0);
      cmd(CMD_GUARD_ERASE, 8'h05, 32'h0, 32'h0); chk(v[STAT_EERR], 1'b1);
      rd(OFS_GUARDS, v); chk(v[0], 1'b0);
      cmd(CMD_CLEAR_STATUS, 8'h0, 32'h0, 32'h0);
      $display("guard test done");
   endtask
   task automatic t_password();
      cmd(CMD_PASS_PROG, 8'h0, 32'h1234_5678, 32'hffff_0000);
      cmd(CMD_PASS_PROG, 8'h0, 32'hffff_ffff, 32'hffff_ffff);
      rd(OFS_PASS_LO, v); chk(v, 32'h1234_5678);
      cmd(CMD_MODE_PROG, 8'h0, 32'h2, 32'h0);
      rd(OFS_MODE, v); chk(v, 32'hffff_fffb);
      rd(OFS_PASS_LO, v); chk(v, 32'hffff_ffff);
      cmd(CMD_CONFIG_PROG, 8'h0, 32'h3c, 32'h0); chk(v[STAT_PERR], 1'b1);
      cmd(CMD_CLEAR_STATUS, 8'h0, 32'h0, 32'h0);
      @(posedge aclk) hw_reset_n <= 0;
      repeat (8) @(posedge aclk);
      hw_reset_n <= 1;
      repeat (8) @(posedge aclk);
      rd(OFS_LOCK, v); chk(v[0], 1'b0);
      cmd(CMD_PASS_UNLOCK, 8'h0, 32'h1234_5678, 32'hffff_0001); chk(v[STAT_PERR], 1'b1);
      rd(OFS_LOCK, v); chk(v[0], 1'b0);
      cmd(CMD_CLEAR_STATUS, 8'h0, 32'h0, 32'h0);
      cmd(CMD_PASS_UNLOCK, 8'h0, 32'h1234_5678, 32'hffff_0000);
      rd(OFS_LOCK, v); chk(v[0], 1'b1);
      $display("password test done");
   endtask
   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1;
      t_reset();
      t_guard();
      t_password();
      stop_test();
   end
endmodule
`default_nettype wire
